//--- hw/scr_pkg.sv
package scr_pkg;
  // ------------------------------------------------------------
  // software register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BC_BIT = 4;
  localparam int CTRL_DEV_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_PEND_BIT = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // serial opcodes and packet layout
  // ------------------------------------------------------------
  localparam logic [3:0] OP_REG_READ = 4'h0;
  localparam logic [3:0] OP_REG_WRITE = 4'h1;
  localparam logic [3:0] OP_ASSERT_RESET = 4'h2;
  localparam logic [3:0] OP_FAST_CLOCK = 4'h4;
  localparam logic [3:0] OP_RELEASE_RESET = 4'hB;
  localparam logic [3:0] OP_NOP = 4'hF;
  localparam logic [7:0] FRAME_PATTERN = 8'hF0;
  localparam logic [6:0] LAST_CYCLE_LONG = 7'h3F;
  localparam logic [6:0] LAST_CYCLE_SHORT = 7'h0F;
  localparam logic [6:0] READ_WINDOW_FIRST = 7'h30;
  localparam logic [6:0] READ_CAPTURE_FIRST = 7'h31;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 50000;
  localparam int SCK_PERIOD_PS = 400000;
  localparam int SCK_DIV = SCK_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [2:0] PH_RISE = 3'h0;
  localparam logic [2:0] PH_MID_HIGH = 3'h2;
  localparam logic [2:0] PH_FALL = 3'h4;
  localparam logic [2:0] PH_MID_LOW = 3'h6;
  localparam logic [2:0] PH_IDLE = 3'h7;
  localparam int CHAN_CYCLE_PS = 2000;
  localparam int RESET_GAP_SCK = 16;
  localparam int RESET_GAP_CHAN = 2816;
  localparam int POST_GAP_SCK = 4;
  localparam int GAP_A = RESET_GAP_SCK * SCK_DIV;
  localparam int GAP_B = (RESET_GAP_CHAN * CHAN_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [8:0] GAP_RESET_CLK = 9'((GAP_A > GAP_B) ? GAP_A : GAP_B);
  localparam logic [8:0] GAP_POST_CLK = 9'(POST_GAP_SCK * SCK_DIV);
  localparam logic [8:0] GAP_PLAIN_CLK = 9'(SCK_DIV);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP} scr_state_t;
endpackage : scr_pkg

//--- hw/scr_sck_gen.sv
module scr_sck_gen
  import scr_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // control
  input wire logic i_run,
  // serial clock
  output logic o_sck,
  output logic [2:0] o_phase
);
  typedef struct packed {
    logic sck;
    logic [2:0] phase;
  } scr_gen_t;

  scr_gen_t s;
  scr_gen_t next_s;

  // ------------------------------------------------------------
  // divider: rise at phase 0, fall at phase 4
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (i_run) begin
      next_s.phase = s.phase + 3'h1;
      next_s.sck = (next_s.phase < PH_FALL);
    end else begin
      next_s.phase = PH_IDLE;
      next_s.sck = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '{sck: 1'b0, phase: PH_IDLE};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_sck = s.sck;
  assign o_phase = s.phase;
endmodule : scr_sck_gen

//--- hw/scr_host.sv
// What this block does
// - serial clock and command line go out once, shared by every device
// - one serial data pin, wired to first device's upstream pin
// - register read and write send four packets of sixteen bits
// - every transaction opens with request packet framed by 11110000 on command
// - write sends 16 data bits as third packet
// - write ends with an all-zero interval packet
// - read sends interval after address, then device returns data packet
// - serial clock period long enough for chain round trip
// - reset and fast-clock commands are a single request packet
// - request: device top bit cycle 5, opcode 6-9, broadcast 10, rest 11-15
// - address packet: four zero cycles then address msb first
// - interval packet all zero; data packet msb first
// - opcodes: read 0, write 1, assert reset 2, fast 4, release B, nop F
// - reserved bits always sent as zero
// - assert and release reset only as a pair, with long gap between
//
// Decided for this implementation: the strobed register port and the register addresses.
module scr_host
  import scr_pkg::*;
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // software port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // serial link
  output logic O_SCK,
  output logic O_CMD,
  output logic O_SIO,
  output logic O_SIO_OE,
  input wire logic I_SIO
);
  typedef struct packed {
    scr_state_t state;
    logic [6:0] cyc;
    logic [63:0] tx;
    logic [15:0] rx;
    logic cmd;
    logic sio;
    logic sio_oe;
    logic sio_meta;
    logic sio_sync;
    logic [8:0] gap;
    logic [3:0] op;
    logic bc;
    logic [5:0] dev;
    logic [11:0] reg_addr;
    logic [15:0] wdata;
    logic done;
    logic refused;
    logic reset_pending;
    logic [31:0] rdata;
  } scr_host_t;

  scr_host_t s;
  scr_host_t next_s;
  logic sck;
  logic [2:0] phase;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [63:0] build_frame(input logic [3:0] op, input logic bc,
                                              input logic [5:0] dev, input logic [11:0] ra,
                                              input logic [15:0] wd);
    logic [15:0] req;
    logic [15:0] adr;
    req = {5'h00, dev[5], op, bc, dev[4:0]};
    adr = {4'h0, ra};
    if (op == OP_REG_WRITE) begin
      build_frame = {req, adr, wd, 16'h0000};
    end else if (op == OP_REG_READ) begin
      build_frame = {req, adr, 16'h0000, 16'h0000};
    end else begin
      build_frame = {req, 48'h0000_0000_0000};
    end
  endfunction : build_frame

  function automatic logic cmd_bit(input logic [7:0] idx);
    cmd_bit = (idx < 8'h08) ? FRAME_PATTERN[3'(8'h07 - idx)] : 1'b0;
  endfunction : cmd_bit

  function automatic logic is_long(input logic [3:0] op);
    is_long = (op == OP_REG_READ) || (op == OP_REG_WRITE);
  endfunction : is_long

  function automatic logic [8:0] gap_for(input logic [3:0] op);
    if (op == OP_ASSERT_RESET) begin
      gap_for = GAP_RESET_CLK;
    end else if (op == OP_RELEASE_RESET || op == OP_FAST_CLOCK) begin
      gap_for = GAP_POST_CLK;
    end else begin
      gap_for = GAP_PLAIN_CLK;
    end
  endfunction : gap_for

  function automatic logic [15:0] shift_in(input logic [15:0] word, input logic b);
    shift_in = {word[14:0], b};
  endfunction : shift_in

  function automatic logic [31:0] status_word(input logic b, input logic d,
                                              input logic r, input logic p);
    status_word = 32'h0000_0000;
    status_word[ST_BUSY_BIT] = b;
    status_word[ST_DONE_BIT] = d;
    status_word[ST_REFUSED_BIT] = r;
    status_word[ST_PEND_BIT] = p;
  endfunction : status_word

  function automatic logic [31:0] ctrl_word(input logic [3:0] op, input logic bc,
                                            input logic [5:0] dev);
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_OP_LSB +: 4] = op;
    ctrl_word[CTRL_BC_BIT] = bc;
    ctrl_word[CTRL_DEV_LSB +: 6] = dev;
  endfunction : ctrl_word

  // ------------------------------------------------------------
  // serial clock divider
  // ------------------------------------------------------------
  scr_sck_gen u_sck_gen (
    .i_clk(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_run(s.state == ST_SHIFT || s.state == ST_TAIL),
    .o_sck(sck),
    .o_phase(phase)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] new_op;
    logic [6:0] last;
    logic [7:0] half;
    logic busy;
    new_op = I_WDATA[CTRL_OP_LSB +: 4];
    last = is_long(s.op) ? LAST_CYCLE_LONG : LAST_CYCLE_SHORT;
    half = {1'b0, s.cyc} << 1;
    busy = (s.state != ST_IDLE);
    next_s = s;
    next_s.sio_meta = I_SIO;
    next_s.sio_sync = s.sio_meta;
    next_s.rdata = 32'h0000_0000;

    // ------------------------------------------------------------
    // software reads
    // ------------------------------------------------------------
    if (I_RD) begin
      case (I_ADDR)
        REG_CTRL: begin
          next_s.rdata = ctrl_word(s.op, s.bc, s.dev);
        end
        REG_ADDR: begin
          next_s.rdata = 32'(s.reg_addr);
        end
        REG_WDATA: begin
          next_s.rdata = 32'(s.wdata);
        end
        REG_STATUS: begin
          next_s.rdata = status_word(busy, s.done, s.refused, s.reset_pending);
        end
        REG_RDATA: begin
          next_s.rdata = 32'(s.rx);
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // ------------------------------------------------------------
    // software writes; status clears first so hardware sets win
    // ------------------------------------------------------------
    if (I_WR) begin
      case (I_ADDR)
        REG_ADDR: begin
          next_s.reg_addr = I_WDATA[11:0];
        end
        REG_WDATA: begin
          next_s.wdata = I_WDATA[15:0];
        end
        REG_STATUS: begin
          if (I_WDATA[ST_DONE_BIT]) begin
            next_s.done = 1'b0;
          end
          if (I_WDATA[ST_REFUSED_BIT]) begin
            next_s.refused = 1'b0;
          end
        end
        REG_CTRL: begin
          if (busy || (s.reset_pending != (new_op == OP_RELEASE_RESET))) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.op = new_op;
            next_s.bc = I_WDATA[CTRL_BC_BIT];
            next_s.dev = I_WDATA[CTRL_DEV_LSB +: 6];
            next_s.tx = build_frame(new_op, I_WDATA[CTRL_BC_BIT],
                                    I_WDATA[CTRL_DEV_LSB +: 6], s.reg_addr, s.wdata);
            next_s.sio = next_s.tx[63];
            next_s.sio_oe = 1'b1;
            next_s.cmd = cmd_bit(8'h00);
            next_s.cyc = 7'h00;
            next_s.rx = 16'h0000;
            next_s.done = 1'b0;
            next_s.reset_pending = (new_op == OP_ASSERT_RESET);
            next_s.state = ST_SHIFT;
          end
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------
    // serial sequencer
    // ------------------------------------------------------------
    case (s.state)
      ST_IDLE: begin
      end
      ST_SHIFT: begin
        if (phase == PH_MID_HIGH) begin
          next_s.cmd = cmd_bit(half + 8'h01);
          if (s.op == OP_REG_READ && s.cyc >= READ_CAPTURE_FIRST) begin
            next_s.rx = shift_in(s.rx, s.sio_sync);
          end
        end else if (phase == PH_MID_LOW) begin
          if (s.cyc == last) begin
            next_s.sio = 1'b0;
            next_s.cmd = 1'b0;
            if (s.op == OP_REG_READ) begin
              next_s.state = ST_TAIL;
            end else begin
              next_s.sio_oe = 1'b1;
              next_s.gap = gap_for(s.op);
              next_s.state = ST_GAP;
            end
          end else begin
            next_s.cyc = s.cyc + 7'h01;
            next_s.cmd = cmd_bit(half + 8'h02);
            next_s.tx = {s.tx[62:0], 1'b0};
            next_s.sio = s.tx[62];
            next_s.sio_oe = !(s.op == OP_REG_READ && (s.cyc + 7'h01) >= READ_WINDOW_FIRST);
          end
        end
      end
      ST_TAIL: begin
        if (phase == PH_MID_HIGH) begin
          next_s.rx = shift_in(s.rx, s.sio_sync);
        end else if (phase == PH_MID_LOW) begin
          // wire stays released until last read bit is taken
          next_s.sio = 1'b0;
          next_s.sio_oe = 1'b1;
          next_s.gap = gap_for(s.op);
          next_s.state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (s.gap <= 9'h001) begin
          next_s.gap = 9'h000;
          next_s.done = 1'b1;
          next_s.state = ST_IDLE;
        end else begin
          next_s.gap = s.gap - 9'h001;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s <= '{state: ST_IDLE, sio_oe: 1'b1, default: '0};
    end else if (I_CE) begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign O_RDATA = s.rdata;
  assign O_SCK = sck;
  assign O_CMD = s.cmd;
  assign O_SIO = s.sio;
  assign O_SIO_OE = s.sio_oe;
endmodule : scr_host

//--- tb/scr_host_chk.sv
module scr_host_chk (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // serial link
  input wire logic O_SCK,
  input wire logic O_CMD,
  input wire logic O_SIO,
  input wire logic O_SIO_OE
);
  // ------
  // link timing checks
  // ------
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_open;
    !O_SCK ##1 O_SCK;
  endsequence
  sequence s_quiet;
    !O_CMD [*8] ##1 !O_CMD [*8];
  endsequence
  a_frame_open: assert property ($rose(O_CMD) |-> s_open)
    else $error("frame start off");
  a_frame_tail: assert property ($fell(O_CMD) |-> s_quiet)
    else $error("frame tail short");
  a_sck_high: assert property ($rose(O_SCK) |-> O_SCK [*4] ##1 !O_SCK)
    else $error("sck high phase wrong");
  a_sck_low: assert property ($fell(O_SCK) |-> !O_SCK [*4])
    else $error("sck low phase short");
  a_sio_setup: assert property ($changed(O_SIO) |-> !O_SCK)
    else $error("data moved with sck high");
  a_read_turn: assert property ($fell(O_SIO_OE) |-> !O_SCK ##1 !O_SIO_OE [*8])
    else $error("turnaround off");
  a_read_bound: assert property ($fell(O_SIO_OE) |-> ##[100:150] O_SIO_OE)
    else $error("read window length");
  a_turn_quiet: assert property (!O_SIO_OE |-> !O_CMD)
    else $error("framing during read");
endmodule : scr_host_chk
bind scr_host scr_host_chk scr_host_chk_i (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
  .O_SCK(O_SCK), .O_CMD(O_CMD), .O_SIO(O_SIO), .O_SIO_OE(O_SIO_OE));

//--- tb/scr_dev_model.sv
module scr_dev_model
  import scr_pkg::*;
#(
  parameter logic [5:0] CHAIN_ID = 6'h03
) (
  // serial link
  input wire logic i_sck,
  input wire logic i_cmd,
  input wire logic i_sio,
  input wire logic i_sio_oe,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // device model
  // ------
  logic [15:0] regs [4096] = '{default: 16'h0000};
  logic [63:0] sh;
  logic [15:0] rv;
  logic [11:0] ra;
  logic [3:0] op;
  logic act = 1'b0;
  logic sel = 1'b0;
  logic d_oe = 1'b0;
  logic d_bit = 1'b0;
  int cnt;
  // released wire shows the inverse of the last bit
  assign o_line = i_sio_oe ? i_sio : (d_oe ? d_bit : ~d_bit);
  always @(posedge i_sck) if (!act && i_cmd) begin
    act = 1'b1;
    cnt = 0;
  end
  always @(negedge i_sck) begin
    d_oe = 1'b0;
    if (act) begin
      if (op == OP_REG_READ && sel && cnt >= 48) begin
        d_oe = 1'b1;
        d_bit = rv[63 - cnt];
      end
      sh = {sh[62:0], i_sio};
      cnt++;
      if (cnt == 16) begin
        op = sh[9:6];
        sel = sh[5] || ({sh[10], sh[4:0]} == CHAIN_ID);
        if (op != OP_REG_READ && op != OP_REG_WRITE) act = 1'b0;
        if (sel && op == OP_ASSERT_RESET) regs = '{default: 16'h0000};
      end
      if (cnt == 32) begin
        ra = sh[11:0];
        rv = regs[ra];
      end
      if (cnt == 48 && sel && op == OP_REG_WRITE) regs[ra] = sh[15:0];
      if (cnt == 64) act = 1'b0;
    end
  end
endmodule : scr_dev_model

//--- tb/testbench.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module testbench
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // bench
  // ------
  logic clk, resetn, wstb, rstb, sck, cmd, sio_o, sio_oe, sio_i;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, s;
  logic [3:0] ops [3] = '{OP_FAST_CLOCK, OP_NOP, 4'h3};
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  scr_host scr_host_i (.I_CLOCK(clk), .I_RESETN(resetn), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wstb), .I_RD(rstb), .O_RDATA(rdata), .O_SCK(sck), .O_CMD(cmd),
    .O_SIO(sio_o), .O_SIO_OE(sio_oe), .I_SIO(sio_i));
  scr_dev_model scr_dev_model_i (.i_sck(sck), .i_cmd(cmd), .i_sio(sio_o), .i_sio_oe(sio_oe),
    .o_line(sio_i));
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd
  task automatic go(input logic [5:0] dv, input logic bc, input logic [3:0] o);
    reg_wr(REG_CTRL, {18'h0_0000, dv, 3'h0, bc, o});
  endtask : go
  task automatic done_wait;
    int i;
    i = 0;
    s = 32'h0000_0000;
    while (s[ST_DONE_BIT] !== 1'b1 && i < 3000) begin
      reg_rd(REG_STATUS, s);
      i++;
    end
    `CHK(s[ST_DONE_BIT], 1'b1)
    reg_wr(REG_STATUS, 32'h0000_0006);
  endtask : done_wait
  task automatic refuse(input logic [5:0] dv, input logic [3:0] o);
    go(dv, 1'b0, o);
    reg_rd(REG_STATUS, s);
    `CHK(s[ST_REFUSED_BIT], 1'b1)
    reg_wr(REG_STATUS, 32'h0000_0006);
  endtask : refuse
  task automatic xfer(input logic [5:0] dv, input logic bc, input logic [3:0] o,
                      input logic [11:0] ra, input logic [15:0] wd);
    reg_wr(REG_ADDR, {20'h0_0000, ra});
    reg_wr(REG_WDATA, {16'h0000, wd});
    go(dv, bc, o);
    done_wait;
  endtask : xfer
  task automatic rd_chk(input logic [11:0] ra, input logic [15:0] e);
    xfer(6'h03, 1'b0, OP_REG_READ, ra, 16'h0000);
    reg_rd(REG_RDATA, s);
    `CHK(s, {16'h0000, e})
  endtask : rd_chk
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    resetn = 1'b0;
    wstb = 1'b0;
    rstb = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK({sck, cmd, sio_oe}, 3'h1)
    reg_rd(8'h14, s);
    `CHK(s, 32'h0000_0000)
    xfer(6'h00, 1'b1, OP_REG_WRITE, 12'h123, 16'hA5C3);
    xfer(6'h05, 1'b0, OP_REG_WRITE, 12'h123, 16'h1111);
    xfer(6'h03, 1'b0, OP_REG_WRITE, 12'h800, 16'h8001);
    reg_rd(REG_CTRL, s);
    `CHK(s, 32'h0000_0301)
    rd_chk(12'h123, 16'hA5C3);
    rd_chk(12'h800, 16'h8001);
    go(6'h03, 1'b0, OP_REG_WRITE);
    refuse(6'h03, OP_REG_WRITE);
    done_wait;
    foreach (ops[i]) xfer(6'h03, 1'b0, ops[i], 12'h000, 16'h0000);
    rd_chk(12'h123, 16'hA5C3);
    refuse(6'h03, OP_RELEASE_RESET);
    xfer(6'h00, 1'b1, OP_ASSERT_RESET, 12'h000, 16'h0000);
    reg_rd(REG_STATUS, s);
    `CHK(s[ST_PEND_BIT], 1'b1)
    refuse(6'h03, OP_REG_READ);
    xfer(6'h00, 1'b1, OP_RELEASE_RESET, 12'h000, 16'h0000);
    rd_chk(12'h123, 16'h0000);
    complete_run;
  end
endmodule : testbench
